// ==== eirq_pkg.sv ====
// Constants and carrier types for the external interrupt pin latch.
// Assumes an 8-bit register port driven from the core clock domain.
package eirq_pkg;

	localparam int EIRQ_AW = 8;
	localparam int EIRQ_DW = 8;

	// Register offsets
	localparam logic [EIRQ_AW-1:0] EIRQ_OFS_STATUS_CONTROL = 8'h00;
	localparam logic [EIRQ_AW-1:0] EIRQ_OFS_BREAK_CONTROL = 8'h01;

	// Field positions in ext_int_status_control
	localparam int EIRQ_BIT_PENDING = 3;
	localparam int EIRQ_BIT_ACK = 2;
	localparam int EIRQ_BIT_MASK = 1;
	localparam int EIRQ_BIT_MODE = 0;

	// Field position in break_flag_control_reg
	localparam int EIRQ_BIT_BREAK_CLEAR = 7;

	// Reset values
	localparam logic EIRQ_RST_MASK = 1'b0;
	localparam logic EIRQ_RST_MODE = 1'b0;
	localparam logic EIRQ_RST_BREAK_CLEAR = 1'b0;
	localparam logic [EIRQ_DW-1:0] EIRQ_RST_RDATA = 8'h00;

	// Vector locations loaded by the CPU
	localparam logic [15:0] EIRQ_VECTOR_HIGH = 16'hFFFA;
	localparam logic [15:0] EIRQ_VECTOR_LOW = 16'hFFFB;

	typedef struct packed {
		logic [EIRQ_AW-1:0] addr;
		logic [EIRQ_DW-1:0] wdata;
		logic wr;
		logic rd;
	} eirq_bus_req_s;

endpackage : eirq_pkg

// ==== eirq_latch.sv ====
// External interrupt pin latch with status/control register port.
// Assumes vector fetch and break state come from core_clk logic,
// while the interrupt pin is asynchronous to core_clk.
//
// Summary of operation
// - A falling edge on the active-low pin sets the latch.
// - The CPU vector fetch acknowledge clears the latch it served.
// - Writing one to the acknowledge bit clears the latch.
// - Reset clears latch and sensitivity select even with pin low.
// - Edge-only after reset; select bit adds low-level sensitivity.
// - Select at 0: any acknowledge clears the latch at once.
// - Select at 1: clear needs acknowledge and pin high, either order.
// - Edge-and-level mode keeps request pending while pin held low.
// - Mask withholds request from priority logic, latch unchanged.
// - A falling edge after software acknowledge latches a new request.
// - Unmasked request makes CPU fetch vector from the two locations.
// - Pending flag shows latch state regardless of the mask.
// - Acknowledge bit is write-only, reads zero, cleared by reset.
// - Mask bit is read/write, one disables, reset clears it.
// - Select bit read/write, reset clears, one adds low levels.
// - Current pin level is given to CPU branch-on-pin instructions.
// - In break with clear enable at one, acknowledges clear the latch.
// - In break with clear enable at zero, acknowledge writes are ignored.
//
// Local design decisions: the strobed register port and the register addresses.
module eirq_latch
	import eirq_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic irq_pin_n,
	input wire logic vector_fetch_ack,
	input wire logic break_state,
	input wire eirq_bus_req_s bus_req,
	output logic [EIRQ_DW-1:0] bus_rdata,
	output logic irq_request,
	output logic [15:0] irq_vector_high,
	output logic [15:0] irq_vector_low,
	output logic pin_level
);

	logic sync1_r;
	logic sync2_r;
	logic sample_prev_r;
	logic falling_edge;
	logic pin_low;
	logic latch_r;
	logic latch_nxt;
	logic mask_r;
	logic mode_r;
	logic break_clear_r;
	logic sw_ack;
	logic any_ack;
	logic sc_write;
	logic bc_write;
	logic [EIRQ_DW-1:0] rdata_nxt;
	logic [2:0] warm_r;
	logic pending;

	// Address match, shared by the write strobes and the rd_upper_a check
	function automatic logic hits(input eirq_bus_req_s req,
		input logic [EIRQ_AW-1:0] ofs);
		hits = (req.addr == ofs);
	endfunction

	// Two flops before any logic; pin idles high
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			sample_prev_r <= 1'b1;
		end else begin
			sync1_r <= irq_pin_n;
			sync2_r <= sync1_r;
			sample_prev_r <= sync2_r;
		end
	end

	// Edge detect waits until the chain holds real pin samples, so a pin
	// held low through reset cannot fake an edge; an edge in those first
	// cycles is lost, the level term still covers level mode
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			warm_r <= 3'h0;
		end else begin
			warm_r <= {warm_r[1:0], 1'b1};
		end
	end

	assign falling_edge = warm_r[2] & sample_prev_r & ~sync2_r;
	assign pin_low = ~sync2_r;

	assign sc_write = bus_req.wr && hits(bus_req, EIRQ_OFS_STATUS_CONTROL);
	assign bc_write = bus_req.wr && hits(bus_req, EIRQ_OFS_BREAK_CONTROL);

	// Ack bit has no storage, so it can never read back
	assign sw_ack = sc_write && bus_req.wdata[EIRQ_BIT_ACK]
		&& (!break_state || break_clear_r);
	assign any_ack = vector_fetch_ack | sw_ack;

	// Set wins over any acknowledge in the same cycle
	always_comb begin
		latch_nxt = falling_edge
			| (latch_r & ~any_ack);
	end

	// Level term sits outside the latch, so an acknowledge taken while
	// the pin is low still counts once the pin returns high
	assign pending = latch_r | (mode_r & pin_low);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_r <= 1'b0;
		end else begin
			latch_r <= latch_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= EIRQ_RST_MASK;
			mode_r <= EIRQ_RST_MODE;
		end else if (sc_write) begin
			mask_r <= bus_req.wdata[EIRQ_BIT_MASK];
			mode_r <= bus_req.wdata[EIRQ_BIT_MODE];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			break_clear_r <= EIRQ_RST_BREAK_CLEAR;
		end else if (bc_write) begin
			break_clear_r <= bus_req.wdata[EIRQ_BIT_BREAK_CLEAR];
		end
	end

	always_comb begin
		rdata_nxt = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				EIRQ_OFS_STATUS_CONTROL: begin
					rdata_nxt[EIRQ_BIT_PENDING] = pending;
					rdata_nxt[EIRQ_BIT_ACK] = 1'b0;
					rdata_nxt[EIRQ_BIT_MASK] = mask_r;
					rdata_nxt[EIRQ_BIT_MODE] = mode_r;
				end
				EIRQ_OFS_BREAK_CONTROL: begin
					rdata_nxt[EIRQ_BIT_BREAK_CLEAR] = break_clear_r;
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	// Read data only valid the cycle after the strobe
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= EIRQ_RST_RDATA;
		end else begin
			bus_rdata <= rdata_nxt;
		end
	end

	assign irq_request = pending & ~mask_r;
	assign irq_vector_high = EIRQ_VECTOR_HIGH;
	assign irq_vector_low = EIRQ_VECTOR_LOW;
	// Synchronised, so it lags the pin by two cycles
	assign pin_level = sync2_r;

	sequence edge_seen_s;
		warm_r[2] && sample_prev_r && !sync2_r;
	endsequence

	sequence fetch_s;
		vector_fetch_ack && !falling_edge;
	endsequence

	sequence sw_ack_ok_s;
		sc_write && bus_req.wdata[EIRQ_BIT_ACK]
			&& (!break_state || break_clear_r);
	endsequence

	edge_sets_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		edge_seen_s |=> latch_r)
		else $error("Falling edge did not set latch");

	fetch_clears_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		vector_fetch_ack && !mode_r && !falling_edge |=> !latch_r)
		else $error("Vector fetch did not clear latch");

	sw_clears_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		sw_ack_ok_s ##0 (!mode_r && !falling_edge) |=> !latch_r)
		else $error("Software acknowledge did not clear latch");

	level_holds_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		mode_r && pin_low |-> pending && irq_request == !mask_r)
		else $error("Level mode dropped request with pin low");

	level_wait_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		latch_r && mode_r && !pin_low && !any_ack && !falling_edge
		|=> latch_r)
		else $error("Level mode cleared without acknowledge");

	mask_gates_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		irq_request == (pending && !mask_r))
		else $error("Request output disagrees with mask");

	break_block_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		latch_r && break_state && !break_clear_r && !vector_fetch_ack
		|=> latch_r)
		else $error("Acknowledge cleared latch during protected break");

	ack_reads_zero_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		bus_req.rd && bus_req.addr == EIRQ_OFS_STATUS_CONTROL
		|=> !bus_rdata[EIRQ_BIT_ACK]
			&& bus_rdata[EIRQ_BIT_PENDING] == $past(pending))
		else $error("Status read data wrong");

	mode_write_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		sc_write |=> mode_r == $past(bus_req.wdata[EIRQ_BIT_MODE])
			&& mask_r == $past(bus_req.wdata[EIRQ_BIT_MASK]))
		else $error("Control bits not written");

	pin_follow_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		1'b1 |-> ##2 pin_level == $past(irq_pin_n, 2))
		else $error("Pin level not two cycles behind pin");

	reset_clear_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		warm_r == 3'h1 |-> !latch_r && !mode_r && !mask_r)
		else $error("State not cleared by reset");

	reset_no_edge_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		!warm_r[2] |-> !falling_edge)
		else $error("Edge seen before sync chain filled");

	reset_pin_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		warm_r == 3'h1 |-> pin_level)
		else $error("Pin level not idle after reset");

	no_edge_set_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		!latch_r && !falling_edge |=> !latch_r)
		else $error("Latch set without an edge");

	any_ack_clr_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		latch_r && any_ack && !falling_edge |=> !latch_r)
		else $error("Acknowledge did not clear latch");

	fetch_mode1_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		fetch_s ##0 mode_r |=> !latch_r)
		else $error("Vector fetch did not clear level mode latch");

	pin_high_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		!latch_r && !pin_low |-> !pending)
		else $error("Request pending with latch clear and pin high");

	edge_after_ack_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		sw_ack_ok_s ##1 edge_seen_s |=> latch_r)
		else $error("Edge after acknowledge not latched");

	mask_keep_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		sc_write && bus_req.wdata[EIRQ_BIT_MASK]
			&& !bus_req.wdata[EIRQ_BIT_ACK] && latch_r
			&& !vector_fetch_ack
		|=> latch_r)
		else $error("Mask write changed latch");

	request_out_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		pending && !mask_r |-> irq_request)
		else $error("Unmasked request not presented");

	vector_const_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		irq_vector_high == EIRQ_VECTOR_HIGH
			&& irq_vector_low == EIRQ_VECTOR_LOW)
		else $error("Vector locations wrong");

	break_clear_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		sw_ack_ok_s ##0 (break_state && !falling_edge)
		|=> !latch_r)
		else $error("Enabled break acknowledge did not clear latch");

	break_write_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		bc_write |=> break_clear_r
			== $past(bus_req.wdata[EIRQ_BIT_BREAK_CLEAR]))
		else $error("Break clear enable not written");

	rd_idle_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		!bus_req.rd |=> bus_rdata == '0)
		else $error("Read data not zero without read");

	rd_upper_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		bus_req.rd && hits(bus_req, EIRQ_OFS_STATUS_CONTROL)
		|=> bus_rdata[7:4] == 4'h0)
		else $error("Unused status bits not zero");

endmodule : eirq_latch

// ==== eirq_cpu_model.sv ====
// CPU side model: fetches the vector for a pending request.
// Assumes irq_request is a core_clk level from the latch.
module eirq_cpu_model (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic irq_request,
	output logic vector_fetch_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_r;
	// Fetch lags the request, as a CPU finishes its instruction first
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_r <= 2'h0;
			vector_fetch_ack <= 1'b0;
		end else begin
			vector_fetch_ack <= enable && irq_request && wait_r == 2'h3;
			if (enable && irq_request && !vector_fetch_ack) begin
				wait_r <= wait_r + 2'h1;
			end else begin
				wait_r <= 2'h0;
			end
		end
	end
endmodule // eirq_cpu_model

// ==== external_irq_pin_latch_test.sv ====
// Self-checking bench for the external interrupt pin latch.
// Assumes eirq_pkg and eirq_cpu_model are compiled first.
module external_irq_pin_latch_test;
	import eirq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SC = EIRQ_OFS_STATUS_CONTROL;
	localparam logic [7:0] BC = EIRQ_OFS_BREAK_CONTROL;
	localparam logic [7:0] ACK = 8'(1 << EIRQ_BIT_ACK);
	localparam logic [7:0] MSK = 8'(1 << EIRQ_BIT_MASK);
	localparam logic [7:0] MOD = 8'(1 << EIRQ_BIT_MODE);
	localparam logic [7:0] BCE = 8'(1 << EIRQ_BIT_BREAK_CLEAR);
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic pin_n = 1'b1;
	logic brk = 1'b0;
	logic cpu_en = 1'b0;
	eirq_bus_req_s req = '0;
	logic [7:0] rdata;
	logic irq;
	logic lvl;
	logic vfa;
	logic [15:0] vh;
	logic [15:0] vl;
	int failures = 0;
	int checks_done = 0;
	always #2 core_clk = ~core_clk;
	eirq_latch i_eirq_latch (.core_clk(core_clk), .reset_n(reset_n),
		.irq_pin_n(pin_n), .vector_fetch_ack(vfa), .break_state(brk),
		.bus_req(req), .bus_rdata(rdata), .irq_request(irq),
		.irq_vector_high(vh), .irq_vector_low(vl), .pin_level(lvl));
	eirq_cpu_model i_eirq_cpu_model (.core_clk(core_clk),
		.reset_n(reset_n), .enable(cpu_en), .irq_request(irq),
		.vector_fetch_ack(vfa));
	function automatic logic [7:0] scr(input logic p, m, s);
		scr = 8'h00;
		scr[EIRQ_BIT_PENDING] = p;
		scr[EIRQ_BIT_MASK] = m;
		scr[EIRQ_BIT_MODE] = s;
	endfunction
	task automatic cmp(input string n, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Signal levels are looked at mid-cycle, away from launching edges
	task automatic chk(input string n, input logic e, g);
		@(negedge core_clk);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		req <= '0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, e);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		req <= '0;
		@(negedge core_clk);
		cmp("rdata", {8'h00, e}, {8'h00, rdata});
		@(posedge core_clk);
	endtask
	// Four edges cover the two-flop sync plus the latch
	task automatic pin(input logic v);
		pin_n <= v;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		failures++;
		report_and_stop();
	end
	initial begin
		logic [7:0] d;
		void'($urandom(67048));
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rd(SC, 8'h00);
		cmp("vector", 16'hFFFA, vh);
		cmp("vector", 16'hFFFB, vl);
		chk("level", 1'b1, lvl);
		pin(1'b0);
		chk("irq", 1'b1, irq);
		chk("level", 1'b0, lvl);
		wr(SC, ACK);
		chk("irq", 1'b0, irq);
		pin(1'b1);
		wr(SC, MSK);
		pin(1'b0);
		chk("irq", 1'b0, irq);
		rd(SC, scr(1'b1, 1'b1, 1'b0));
		wr(SC, 8'h00);
		chk("irq", 1'b1, irq);
		cpu_en <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("irq", 1'b0, irq);
		cpu_en <= 1'b0;
		pin(1'b1);
		wr(SC, MOD);
		pin(1'b0);
		wr(SC, ACK | MOD);
		chk("irq", 1'b1, irq);
		pin(1'b1);
		chk("irq", 1'b0, irq);
		pin(1'b0);
		pin(1'b1);
		chk("irq", 1'b1, irq);
		wr(SC, ACK | MOD);
		chk("irq", 1'b0, irq);
		wr(SC, MOD | MSK);
		pin(1'b0);
		chk("irq", 1'b0, irq);
		rd(SC, scr(1'b1, 1'b1, 1'b1));
		wr(SC, ACK | MOD | MSK);
		pin(1'b1);
		rd(SC, scr(1'b0, 1'b1, 1'b1));
		wr(SC, 8'h00);
		pin(1'b0);
		brk <= 1'b1;
		wr(SC, ACK);
		chk("irq", 1'b1, irq);
		wr(BC, BCE);
		wr(SC, ACK);
		brk <= 1'b0;
		@(posedge core_clk);
		chk("irq", 1'b0, irq);
		wr(BC, 8'h00);
		pin(1'b1);
		for (int i = 0; i < 20; i++) begin
			d = 8'($urandom);
			wr(SC, d);
			rd(SC, scr(1'b0, d[EIRQ_BIT_MASK], d[EIRQ_BIT_MODE]));
			rd(8'h02 + 8'($urandom % 254), 8'h00);
		end
		wr(SC, MOD);
		pin(1'b0);
		reset_n <= 1'b0;
		@(posedge core_clk);
		chk("irq", 1'b0, irq);
		reset_n <= 1'b1;
		rd(SC, 8'h00);
		repeat (4) @(posedge core_clk);
		rd(SC, 8'h00);
		chk("level", 1'b0, lvl);
		report_and_stop();
	end
endmodule // external_irq_pin_latch_test
